// *** hdl/bic_pkg.sv ***
// Package for the bus idle cycle inserter: encodings and limits
package bic_pkg;
    // Access master
    typedef enum logic [1:0] {
        BIC_MST_CPU,
        BIC_MST_DMA_DUAL,
        BIC_MST_EVT,
        BIC_MST_DMA_SINGLE
    } bic_master_t;

    // Transfer case (single-address DMA direction / SDRAM masters)
    typedef enum logic [2:0] {
        BIC_CASE_DEV_TO_NORMAL,
        BIC_CASE_NORMAL_TO_DEV,
        BIC_CASE_DEV_TO_SDRAM,
        BIC_CASE_SDRAM_TO_DEV,
        BIC_CASE_SDRAM_MASTER,
        BIC_CASE_NONE
    } bic_case_t;

    // Previous/next direction pair for SDRAM master accesses
    typedef enum logic [1:0] {
        BIC_DIR_RR,
        BIC_DIR_WW,
        BIC_DIR_RW,
        BIC_DIR_WR
    } bic_dir_t;

    // Core-to-bus clock ratio, in listed order
    typedef enum logic [1:0] {
        BIC_RATIO_4_1,
        BIC_RATIO_3_1,
        BIC_RATIO_2_1,
        BIC_RATIO_1_1
    } bic_ratio_t;

    localparam int          BIC_CNT_W         = 3;
    localparam int          BIC_SET_W         = 2;
    // Idle setting code 3 selects four cycles
    localparam logic [1:0]  BIC_IDLE_CODE_4   = 2'h3;
    // Hold-wait codes at or above this give 2.5 cycles or more
    localparam logic [1:0]  BIC_HW_2P5_CODE   = 2'h2;
    localparam logic [2:0]  BIC_IDLE_FOUR     = 3'h4;
    localparam logic [2:0]  BIC_IDLE_FIVE     = 3'h5;
    localparam logic [2:0]  BIC_ONE           = 3'h1;
    localparam logic [2:0]  BIC_TWO           = 3'h2;
    localparam logic [2:0]  BIC_THREE         = 3'h3;
    localparam logic [2:0]  BIC_ZERO          = 3'h0;
    localparam logic [2:0]  BIC_CPU_RW_BASE   = 3'h3;
    localparam logic [2:0]  BIC_CPU_RW_BASE11 = 3'h4;
    localparam logic [2:0]  BIC_DMA_RW_BASE   = 3'h2;
endpackage : bic_pkg

// *** hdl/bic_idle_inserter.sv ***
// Minimum idle cycle computation and gap enforcement between bus cycles
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - DMA and event idle counted in core clocks
// - CPU SDRAM read-write base selected per clock ratio: 4 at 1:1, else 3
// - Split column only for split pieces, bursts
// - Device-to-normal low settings: 0/1, or 1
// - Device-to-normal all-select: 1, 2, 4 cycles
// - Hold wait 2.5+ drops the single idle when external wait is ignored
// - Device-to-normal ignores per-area idle fields
// - Normal-to-device ignores DMA idle fields
// - Normal-to-device table by area idle setting
// - SDRAM read-read: max(precharge, idle+1)
// - SDRAM write-write/read: max(idle, pre+rec-1)
// - CPU SDRAM read-write: max(ratio base, pre, idle+1)
// - DMA SDRAM read-write: max(2, pre, idle+1)
// - Device-to-SDRAM: max(dma idle/1, pre+rec-1)
// - Device-to-SDRAM ignores per-area idle fields
// - SDRAM-to-device: 3, 4 at pre 4, 5
// - Select 0 takes DMA idle count field
// - Select 1 with nonzero count idles after device output always
module bic_idle_inserter (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    // Bus cycle handshake
    input  wire logic                  cycle_end_i,
    input  wire logic                  next_req_i,
    output logic                       next_start_o,
    output logic                       idle_busy_o,
    output logic [bic_pkg::BIC_CNT_W-1:0] idle_min_o,
    // Access description of the pair
    input  wire bic_pkg::bic_case_t    xfer_case_i,
    input  wire bic_pkg::bic_master_t  master_i,
    input  wire bic_pkg::bic_dir_t     dir_i,
    input  wire logic                  split_i,
    input  wire logic                  next_is_dev_out_i,
    // Configuration
    input  wire bic_pkg::bic_ratio_t   ratio_i,
    input  wire logic                  external_wait_ignore_i,
    input  wire logic [1:0]            hold_wait_cycles_i,
    input  wire logic [1:0]            area_idle_i,
    input  wire logic [1:0]            sdram_area_idle_i,
    input  wire logic                  dma_idle_all_select_i,
    input  wire logic [1:0]            dma_idle_count_i,
    input  wire logic [1:0]            precharge_wait_i,
    input  wire logic [1:0]            write_recovery_wait_i
);
    import bic_pkg::*;

    typedef enum {BIC_ST_IDLE, BIC_ST_GAP, BIC_ST_READY} bic_state_t;

    bic_state_t           state_ff;
    logic [BIC_CNT_W-1:0] gap_cnt_ff;
    logic [BIC_CNT_W-1:0] need_ff;
    logic [BIC_CNT_W-1:0] nxt_need;
    logic                 next_start_ff;
    logic                 idle_busy_ff;
    logic [BIC_CNT_W-1:0] idle_min_ff;

    // Setting code 3 means four idle cycles; others are literal
    function automatic logic [2:0] bic_decode(input logic [1:0] code);
        if (code == BIC_IDLE_CODE_4) begin
            bic_decode = BIC_IDLE_FOUR;
        end else begin
            bic_decode = {1'b0, code};
        end
    endfunction : bic_decode

    function automatic logic [2:0] bic_max(input logic [2:0] a,
                                           input logic [2:0] b);
        bic_max = (a > b) ? a : b;
    endfunction : bic_max

    // Idle setting plus one, with four mapping to five
    function automatic logic [2:0] bic_inc(input logic [2:0] v);
        bic_inc = (v == BIC_IDLE_FOUR) ? BIC_IDLE_FIVE : 3'(v + 3'h1);
    endfunction : bic_inc

    logic [2:0] area_set;
    logic [2:0] sdram_set;
    logic [2:0] dma_set;
    logic [2:0] pre_w;
    logic [2:0] pre_rec;

    // Precharge wait codes 0..3 stand for 1..4 cycles
    assign area_set  = bic_decode(area_idle_i);
    assign sdram_set = bic_decode(sdram_area_idle_i);
    assign dma_set   = bic_decode(dma_idle_count_i);
    assign pre_w     = 3'({1'b0, precharge_wait_i} + 3'h1);
    // Precharge plus recovery minus one; recovery 0 gives pre-1
    assign pre_rec   = 3'(pre_w + {1'b0, write_recovery_wait_i} - 3'h1);

    always_comb begin
        logic [2:0] base;
        base     = BIC_ZERO;
        nxt_need = BIC_ZERO;
        case (xfer_case_i)
            BIC_CASE_DEV_TO_NORMAL: begin
                // Per-area idle fields deliberately unused here
                if (dma_idle_all_select_i && dma_set != BIC_ZERO) begin
                    nxt_need = dma_set;
                end else if (external_wait_ignore_i) begin
                    // Split pieces need none with wait ignored
                    nxt_need = split_i ? BIC_ZERO : BIC_ONE;
                    if (hold_wait_cycles_i >= BIC_HW_2P5_CODE) begin
                        nxt_need = BIC_ZERO;
                    end
                end else begin
                    nxt_need = BIC_ONE;
                end
                // Select 0: count guards only another device's output
                if (!dma_idle_all_select_i && next_is_dev_out_i) begin
                    nxt_need = bic_max(nxt_need, dma_set);
                end
            end
            BIC_CASE_NORMAL_TO_DEV: begin
                // DMA idle select and count unused here
                if (area_set == BIC_IDLE_FOUR) begin
                    nxt_need = BIC_IDLE_FOUR;
                end else if (split_i) begin
                    nxt_need = external_wait_ignore_i ? area_set
                             : bic_max(BIC_ONE, area_set);
                end else begin
                    nxt_need = external_wait_ignore_i ? BIC_TWO
                             : BIC_THREE;
                end
            end
            BIC_CASE_DEV_TO_SDRAM: begin
                // Only DMA count and SDRAM waits matter
                // One-cycle floor relies on row-column delay <= 1
                nxt_need = bic_max(bic_max(dma_set, BIC_ONE),
                                   pre_rec);
            end
            BIC_CASE_SDRAM_TO_DEV: begin
                if (sdram_set == BIC_IDLE_FOUR) begin
                    nxt_need = BIC_IDLE_FIVE;
                end else begin
                    nxt_need = (pre_w == BIC_IDLE_FOUR) ? BIC_IDLE_FOUR
                             : BIC_THREE;
                end
            end
            BIC_CASE_SDRAM_MASTER: begin
                case (dir_i)
                    BIC_DIR_RR: begin
                        nxt_need = bic_max(pre_w,
                                           bic_inc(sdram_set));
                    end
                    BIC_DIR_RW: begin
                        // Only CPU minima depend on ratio
                        if (master_i == BIC_MST_CPU) begin
                            base = (ratio_i == BIC_RATIO_1_1)
                                 ? BIC_CPU_RW_BASE11
                                 : BIC_CPU_RW_BASE;
                        end else begin
                            base = BIC_DMA_RW_BASE;
                        end
                        nxt_need = bic_max(bic_max(base, pre_w),
                                           bic_inc(sdram_set));
                    end
                    default: begin
                        nxt_need = bic_max(sdram_set, pre_rec);
                    end
                endcase
            end
            default: begin
                nxt_need = BIC_ZERO;
            end
        endcase
    end

    // Gap sequencer: count core clocks from cycle end
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_ff   <= BIC_ST_IDLE;
            gap_cnt_ff <= BIC_ZERO;
            need_ff    <= BIC_ZERO;
        end else begin
            case (state_ff)
                BIC_ST_IDLE: begin
                    if (cycle_end_i) begin
                        need_ff    <= nxt_need;
                        gap_cnt_ff <= BIC_ZERO;
                        state_ff   <= (nxt_need == BIC_ZERO) ? BIC_ST_READY
                                    : BIC_ST_GAP;
                    end
                end
                BIC_ST_GAP: begin
                    gap_cnt_ff <= 3'(gap_cnt_ff + 3'h1);
                    if (3'(gap_cnt_ff + 3'h1) >= need_ff) begin
                        state_ff <= BIC_ST_READY;
                    end
                end
                BIC_ST_READY: begin
                    if (next_req_i) begin
                        state_ff <= BIC_ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= BIC_ST_IDLE;
                end
            endcase
        end
    end

    // Registered outputs; a start is granted only once the gap is over
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            next_start_ff <= 1'b0;
            idle_busy_ff  <= 1'b0;
            idle_min_ff   <= BIC_ZERO;
        end else begin
            next_start_ff <= (state_ff == BIC_ST_READY) && next_req_i;
            idle_busy_ff  <= (state_ff == BIC_ST_GAP);
            if (state_ff == BIC_ST_IDLE && cycle_end_i) begin
                idle_min_ff <= nxt_need;
            end
        end
    end

    assign next_start_o = next_start_ff;
    assign idle_busy_o  = idle_busy_ff;
    assign idle_min_o   = idle_min_ff;
endmodule : bic_idle_inserter

`default_nettype wire

// *** verification/bic_far_side.sv ***
// Far-side bus model: ends bus cycles on command, then asks for the next
`timescale 1ns/10ps
`default_nettype none
module bic_far_side (
    // Clock and bench control
    input  wire logic core_clk_i,
    input  wire logic go_i,
    input  wire logic slow_i,
    // Bus cycle handshake
    input  wire logic next_start_i,
    output var logic  cycle_end_o,
    output var logic  next_req_o
);
    initial begin
        cycle_end_o = 1'b0;
        next_req_o  = 1'b0;
        forever begin
            @(negedge core_clk_i);
            if (go_i) begin
                cycle_end_o = 1'b1;
                @(negedge core_clk_i);
                cycle_end_o = 1'b0;
                // A slow device asks only after any gap has run out
                repeat (slow_i ? 8 : 0) @(negedge core_clk_i);
                next_req_o = 1'b1;
                for (int n = 0; n < 40 && !next_start_i; n++) begin
                    @(negedge core_clk_i);
                end
                next_req_o = 1'b0;
            end
        end
    end
endmodule : bic_far_side
`default_nettype wire

// *** verification/bic_idle_inserter_asserts.sv ***
// Checker for gap length and grant timing of the idle inserter
`timescale 1ns/10ps
`default_nettype none
module bic_idle_inserter_asserts (
    // Clock and reset
    input wire logic                          core_clk_i,
    input wire logic                          sys_rst_i,
    // Handshake and result
    input wire logic                          cycle_end_i,
    input wire logic                          next_req_i,
    input wire logic                          next_start_o,
    input wire logic                          idle_busy_o,
    input wire logic [bic_pkg::BIC_CNT_W-1:0] idle_min_o
);
    import bic_pkg::*;
    logic [2:0] run_ff;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Busy run length, compared with the minimum when the run ends
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !idle_busy_o) run_ff <= 3'h0;
        else run_ff <= run_ff + 3'h1;
    end
    sequence s_end_zero; cycle_end_i ##1 (idle_min_o == 3'h0); endsequence
    sequence s_long_run; idle_busy_o [*6]; endsequence
    property p_pulse; next_start_o |=> !next_start_o; endproperty
    property p_req; next_start_o |-> $past(next_req_i); endproperty
    property p_hold; idle_busy_o |-> !next_start_o; endproperty
    property p_max; s_long_run |=> !idle_busy_o; endproperty
    property p_upd; !$stable(idle_min_o) |-> $past(cycle_end_i); endproperty
    property p_rise; $rose(idle_busy_o) |-> $past(cycle_end_i, 2); endproperty
    property p_len; $fell(idle_busy_o) |-> run_ff == idle_min_o; endproperty
    property p_zero; s_end_zero |=> !idle_busy_o; endproperty
    a_pulse: assert property (p_pulse) else $error("long grant");
    a_req: assert property (p_req) else $error("grant unasked");
    a_hold: assert property (p_hold) else $error("grant in gap");
    a_max: assert property (p_max) else $error("gap too long");
    a_upd: assert property (p_upd) else $error("stray update");
    a_rise: assert property (p_rise) else $error("late gap");
    a_len: assert property (p_len) else $error("gap length");
    a_zero: assert property (p_zero) else $error("zero gap");
endmodule : bic_idle_inserter_asserts
bind bic_idle_inserter bic_idle_inserter_asserts u_chk (.core_clk_i,
    .sys_rst_i, .cycle_end_i, .next_req_i, .next_start_o, .idle_busy_o,
    .idle_min_o);
`default_nettype wire

// *** verification/bic_idle_inserter_tb_top.sv ***
// Random and corner-case bench for the idle cycle inserter
`timescale 1ns/10ps
`default_nettype none
module bic_idle_inserter_tb_top;
    import bic_pkg::*;
    logic        core_clk_i = 1'b0, sys_rst_i = 1'b1, go = 1'b0, slow;
    logic        cyc_end, req, start, busy, split, ign, sel, dev_out;
    logic [2:0]  idle_min;
    logic [1:0]  hw, area, sarea, dcnt, pre, rec;
    logic [31:0] seed = 32'h46ff;
    bic_case_t   xc;
    bic_master_t mst;
    bic_dir_t    dir;
    bic_ratio_t  ratio;
    int          errors = 0, checks = 0;
    always #10 core_clk_i = ~core_clk_i;
    bic_idle_inserter dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .cycle_end_i(cyc_end), .next_req_i(req), .next_start_o(start),
        .idle_busy_o(busy), .idle_min_o(idle_min), .xfer_case_i(xc),
        .master_i(mst), .dir_i(dir), .split_i(split),
        .next_is_dev_out_i(dev_out), .ratio_i(ratio),
        .external_wait_ignore_i(ign), .hold_wait_cycles_i(hw),
        .area_idle_i(area), .sdram_area_idle_i(sarea),
        .dma_idle_all_select_i(sel), .dma_idle_count_i(dcnt),
        .precharge_wait_i(pre), .write_recovery_wait_i(rec));
    bic_far_side far (.core_clk_i(core_clk_i), .go_i(go), .slow_i(slow),
        .next_start_i(start), .cycle_end_o(cyc_end), .next_req_o(req));
    function automatic int v4(logic [1:0] c); return c == 2'h3 ? 4 : c;
    endfunction : v4
    function automatic int mx(int a, int b); return a > b ? a : b;
    endfunction : mx
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Minimum idle count expected for the current settings
    function automatic logic [7:0] want();
        int e, s;
        s = v4(sarea);
        case (xc)
            BIC_CASE_DEV_TO_NORMAL: e = (sel && dcnt != 0) ? v4(dcnt)
                : (ign && (split || hw >= 2'h2)) ? 0 : 1;
            BIC_CASE_NORMAL_TO_DEV: e = (area == 2'h3) ? 4 : !split ? 3 - ign
                : ign ? v4(area) : mx(1, v4(area));
            BIC_CASE_DEV_TO_SDRAM: e = mx(mx(1, v4(dcnt)), pre + rec);
            BIC_CASE_SDRAM_TO_DEV: e = (sarea == 2'h3) ? 5 : 3 + (pre == 2'h3);
            BIC_CASE_SDRAM_MASTER: e = (dir == BIC_DIR_RR) ? mx(pre + 1, s + 1)
                : (dir != BIC_DIR_RW) ? mx(s, pre + rec) : mx(mx(pre + 1, s + 1),
                (mst != BIC_MST_CPU) ? 2 : (ratio == BIC_RATIO_1_1) ? 4 : 3);
            default: e = 0;
        endcase
        if (xc == BIC_CASE_DEV_TO_NORMAL && !sel && dev_out) e = mx(e, v4(dcnt));
        return 8'(e);
    endfunction : want
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // One bus cycle end with random settings; the first eight are corners
    task automatic run(input int i);
        logic [31:0] r;
        int n;
        seed = lfsr(seed);
        r = (i < 8) ? {32{i[0]}} : seed;
        @(negedge core_clk_i);
        {dev_out, slow, split, rec, pre, dcnt, sel, sarea, area, hw, ign} = r[16:0];
        ratio = bic_ratio_t'(r[18:17]);
        dir = bic_dir_t'(r[20:19]);
        xc = bic_case_t'(3'(i % 6));
        mst = (xc != BIC_CASE_SDRAM_MASTER) ? BIC_MST_DMA_SINGLE
            : bic_master_t'(r[22:21] % 2'h3);
        if (xc == BIC_CASE_SDRAM_MASTER) area = sarea;
        @(posedge core_clk_i) go <= 1'b1;
        @(posedge core_clk_i) go <= 1'b0;
        n = 0;
        for (int k = 0; k <= 60; k++) begin
            @(negedge core_clk_i);
            if (start === 1'b1) break;
            if (k == 60) begin
                errors++;
                report_and_stop();
            end
            n += int'(busy === 1'b1);
        end
        check(8'(n), want());
        case (xc)
            BIC_CASE_DEV_TO_NORMAL: check(8'(idle_min), want());
            BIC_CASE_NORMAL_TO_DEV: check(8'(idle_min), want());
            // Row-column delay taken as one cycle or less here
            BIC_CASE_DEV_TO_SDRAM: check(8'(idle_min), want());
            BIC_CASE_SDRAM_TO_DEV: check(8'(idle_min), want());
            BIC_CASE_SDRAM_MASTER: check(8'(idle_min), want());
            default: check(8'(idle_min), 8'h0);
        endcase
    endtask : run
    initial begin
        {slow, split, ign, sel, dev_out, hw, area, sarea, dcnt, pre, rec} = '0;
        xc = BIC_CASE_NONE;
        mst = BIC_MST_CPU;
        dir = BIC_DIR_RR;
        ratio = BIC_RATIO_4_1;
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i) sys_rst_i = 1'b0;
        for (int i = 0; i < 400; i++) run(i);
        // Reset again in mid-run: outputs must drop and work resume
        @(negedge core_clk_i) sys_rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        check({3'h0, start, busy, idle_min}, 8'h0);
        sys_rst_i = 1'b0;
        run(11);
        report_and_stop();
    end
endmodule : bic_idle_inserter_tb_top
`default_nettype wire
